// *** ddr_sram_port.sv ***
// Device-side port logic of a double-data-rate two-word burst SRAM.
// Assumes all inputs except rst_b synchronous to mclk; each mclk cycle is one half-clock
// beat, with beat_phase marking positive (1) or negative (0) input clock rises.
`include "ddr_sram_port_defines.svh"
module ddr_sram_port #(
    parameter int ADDR_W = `ADDR_W_DEF,
    parameter int LANES  = `LANES_DEF
) (
    // Clock, enable and reset
    input  wire logic                          mclk,
    input  wire logic                          clk_en,
    input  wire logic                          rst_b,
    // Beat phase: high on positive input clock rise
    input  wire logic                          beat_phase,
    // Command
    input  wire logic                          load_strobe_n,
    input  wire logic                          read_write_select,
    input  wire logic [ADDR_W-1:0]             addr_in,
    // Write data with lane selects
    input  wire logic [LANES*`LANE_BITS-1:0]   wr_data,
    input  wire logic [LANES-1:0]              byte_lane_select_n,
    // Read data towards the controller
    output logic      [LANES*`LANE_BITS-1:0]   rd_data,
    output logic                               rd_data_oe,
    // Buffer hand-off to the pin driver
    input  wire logic                          rd_ready
);
    localparam int DW = LANES * `LANE_BITS;

    // All port state except the reset synchronizer and the array
    typedef struct packed {
        ddr_sram_port_pkg::port_state_e state;
        logic [ADDR_W-1:0]  first_burst_address;
        logic [ADDR_W-1:0]  second_burst_address;
        logic               wr_beat2;       // second write beat pending
        logic               hold_valid;     // holding register valid
        logic [ADDR_W-1:0]  hold_addr;
        logic [DW-1:0]      hold_data;
        logic [LANES-1:0]   hold_lanes;
        logic               fetch_v;        // memory read issued last cycle
        logic               fetch_byp;
        logic [DW-1:0]      fetch_byp_data;
        logic [1:0]         buf_v;          // two-entry output buffer
        logic [DW-1:0]      buf0;
        logic [DW-1:0]      buf1;
        logic [DW-1:0]      dout;
        logic               oe;
    } port_s;

    port_s st_r;
    port_s st_nxt;
    logic  rst_meta_r;
    logic  rst_sync_r;
    logic [DW-1:0] mem_rd;
    logic [LANES-1:0] mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [DW-1:0] mem_wdata;
    logic [ADDR_W-1:0] mem_raddr;

    // Spread lane enables to a bit mask
    function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] en);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*`LANE_BITS +: `LANE_BITS] = {`LANE_BITS{en[i]}};
        end
        return m;
    endfunction

    // Partner burst address
    function automatic logic [ADDR_W-1:0] pair_addr(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:1], ~a[0]};
    endfunction

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Next-state logic
    always_comb begin
        logic [DW-1:0] merged;
        logic          start_wr;
        logic          start_rd;
        logic          rd_word;
        logic [ADDR_W-1:0] rd_a;
        logic [DW-1:0] word;
        merged   = '0;
        start_wr = 1'b0;
        start_rd = 1'b0;
        rd_word  = 1'b0;
        rd_a     = st_r.first_burst_address;
        word     = '0;
        st_nxt   = st_r;
        mem_we   = '0;
        mem_waddr = st_r.hold_addr;
        mem_wdata = st_r.hold_data;

        if (beat_phase && !load_strobe_n && st_r.state == ddr_sram_port_pkg::ST_IDLE
            && st_r.buf_v != 2'b11) begin
            start_wr = !read_write_select;
            start_rd = read_write_select;
        end

        // Buffer drain towards the pins
        if (st_r.buf_v[0] && rd_ready) begin
            st_nxt.dout = st_r.buf0;
            st_nxt.oe   = 1'b1;
            st_nxt.buf0 = st_r.buf1;
            st_nxt.buf_v = {1'b0, st_r.buf_v[1]};
        end else if (!st_r.buf_v[0] && rd_ready) begin
            st_nxt.oe = 1'b0;
        end

        // Retire the held beat into the array
        if (st_r.hold_valid && !start_rd) begin
            mem_we    = st_r.hold_lanes;
            st_nxt.hold_valid = 1'b0;
        end

        case (st_r.state)
            ddr_sram_port_pkg::ST_IDLE: begin
                if (start_wr || start_rd) begin
                    st_nxt.first_burst_address  = addr_in;
                    st_nxt.second_burst_address = pair_addr(addr_in);
                end
                if (start_wr) begin
                    st_nxt.state = ddr_sram_port_pkg::ST_WR1;
                end else if (start_rd) begin
                    st_nxt.state = ddr_sram_port_pkg::ST_RD1;
                end
            end
            ddr_sram_port_pkg::ST_WR1: begin
                // beats at next positive then negative rise
                if (beat_phase && !st_r.wr_beat2) begin
                    st_nxt.wr_beat2 = 1'b1;
                    rd_a = st_r.first_burst_address;
                end else if (!beat_phase && st_r.wr_beat2) begin
                    st_nxt.wr_beat2 = 1'b0;
                    st_nxt.state    = ddr_sram_port_pkg::ST_IDLE;
                    rd_a = st_r.second_burst_address;
                end
                if ((beat_phase && !st_r.wr_beat2) || (!beat_phase && st_r.wr_beat2)) begin
                    // selects per beat; lane masks; all high
                    if (st_r.hold_valid) begin
                        mem_we = st_r.hold_lanes;
                    end
                    st_nxt.hold_valid = |(~byte_lane_select_n);
                    st_nxt.hold_addr  = rd_a;
                    st_nxt.hold_lanes = ~byte_lane_select_n;
                    st_nxt.hold_data  = wr_data;
                end
            end
            ddr_sram_port_pkg::ST_RD1: begin
                rd_word = 1'b1;
                rd_a    = st_r.first_burst_address;
                st_nxt.state = ddr_sram_port_pkg::ST_RD2;
            end
            ddr_sram_port_pkg::ST_RD2: begin
                rd_word = 1'b1;
                rd_a    = st_r.second_burst_address;
                st_nxt.state = ddr_sram_port_pkg::ST_IDLE;
            end
            default: begin
                st_nxt.state = ddr_sram_port_pkg::ST_IDLE;
            end
        endcase

        merged = (mem_rd & ~lane_mask(st_r.hold_lanes))
               | (st_r.hold_data & lane_mask(st_r.hold_lanes));
        st_nxt.fetch_v   = rd_word;
        st_nxt.fetch_byp = rd_word && st_r.hold_valid && st_r.hold_addr == rd_a;
        st_nxt.fetch_byp_data = st_r.hold_data;

        if (st_r.fetch_v) begin
            word = st_r.fetch_byp ? merged : mem_rd;
            if (!st_nxt.buf_v[0]) begin
                st_nxt.buf0    = word;
                st_nxt.buf_v[0] = 1'b1;
            end else begin
                st_nxt.buf1    = word;
                st_nxt.buf_v[1] = 1'b1;
            end
        end
    end

    assign mem_raddr = (st_r.state == ddr_sram_port_pkg::ST_RD1) ? st_r.first_burst_address
                                                               : st_r.second_burst_address;

    // State register; deselected after reset
    always_ff @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r       <= '0;
            st_r.state <= ddr_sram_port_pkg::ST_IDLE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Array
    burst_word_mem #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES)
    ) u_mem (
        .mclk       (mclk),
        .clk_en     (clk_en),
        .wr_lane_en (mem_we),
        .wr_addr    (mem_waddr),
        .wr_data    (mem_wdata),
        .rd_addr    (mem_raddr),
        .rd_data    (mem_rd)
    );

    assign rd_data    = st_r.dout;
    assign rd_data_oe = st_r.oe;
endmodule

// *** ddr_sram_port_defines.svh ***
// Constants for the two-word burst SRAM port: lane layout and latencies.
// Assumes inclusion by bare name from the package and design files.
`ifndef DDR_SRAM_PORT_DEFINES_SVH
`define DDR_SRAM_PORT_DEFINES_SVH
`define LANE_BITS        9
`define DATA_W_DEF       36
`define LANES_DEF        4
`define ADDR_W_DEF       8
`define CLK_PERIOD_NS    50
`define WR_FIRST_DELAY   1
`define RD_FIRST_DELAY   1
`endif

// *** ddr_sram_port_pkg.sv ***
// Types for the two-word burst SRAM port.
// Assumes the defines header is present in the same folder.
`include "ddr_sram_port_defines.svh"
package ddr_sram_port_pkg;
    // Port sequencing states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WR1   = 4'b0010,
        ST_RD1   = 4'b0100,
        ST_RD2   = 4'b1000
    } port_state_e;
endpackage

// *** burst_word_mem.sv ***
// Word memory with per-lane write enables and registered read data.
// Assumes one clock and a clock enable from the port logic.
`include "ddr_sram_port_defines.svh"
module burst_word_mem #(
    parameter int ADDR_W = `ADDR_W_DEF,
    parameter int LANES  = `LANES_DEF
) (
    // Clock
    input  wire logic                          mclk,
    input  wire logic                          clk_en,
    // Write side
    input  wire logic [LANES-1:0]              wr_lane_en,
    input  wire logic [ADDR_W-1:0]             wr_addr,
    input  wire logic [LANES*`LANE_BITS-1:0]   wr_data,
    // Read side
    input  wire logic [ADDR_W-1:0]             rd_addr,
    output logic      [LANES*`LANE_BITS-1:0]   rd_data
);
    logic [LANES*`LANE_BITS-1:0] mem [0:(1<<ADDR_W)-1];

    // Lane-masked write and registered read
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_lane_en[i]) begin
                    mem[wr_addr][i*`LANE_BITS +: `LANE_BITS] <=
                        wr_data[i*`LANE_BITS +: `LANE_BITS];
                end
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** ddr_sram_port_props.sv ***
// Checker for the burst SRAM port: read timing, buffer hand-off, quiet outputs.
// Assumes a bind to ddr_sram_port, seeing only its ports.
module ddr_sram_port_props #(
    parameter int ADDR_W = 8,
    parameter int LANES  = 4
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_b,
    // Command
    input wire logic               beat_phase,
    input wire logic               load_strobe_n,
    input wire logic               read_write_select,
    // Read side
    input wire logic [LANES*9-1:0] rd_data,
    input wire logic               rd_data_oe,
    input wire logic               rd_ready
);
    logic       rd_cmd;
    logic       wr_cmd;
    logic [3:0] gap_r;
    // Commands decoded on positive beats
    assign rd_cmd = beat_phase & ~load_strobe_n & read_write_select;
    assign wr_cmd = beat_phase & ~load_strobe_n & ~read_write_select;
    // Cycles since the last command, saturating
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) gap_r <= 4'hf;
        else if (rd_cmd | wr_cmd) gap_r <= 4'h0;
        else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence fresh_read;
        rd_cmd && gap_r == 4'hf && !rd_data_oe && rd_ready;
    endsequence
    sequence two_words;
        rd_data_oe ##1 rd_data_oe ##1 !rd_data_oe;
    endsequence
    chk_read_latency:
        assert property (fresh_read |-> ##4 two_words)
        else $error("read burst timing wrong");
    chk_oe_cause:
        assert property ($rose(rd_data_oe) |-> $past(rd_cmd, 4) || !$past(rd_ready, 2))
        else $error("output enabled without read");
    chk_stall_hold:
        assert property (rd_data_oe && !rd_ready |=> rd_data_oe && $stable(rd_data))
        else $error("stalled word not held");
    chk_fell_taken:
        assert property ($fell(rd_data_oe) |-> $past(rd_ready))
        else $error("word dropped before taken");
    chk_reset_quiet:
        assert property ($rose(rst_b) |-> !rd_data_oe ##1 !rd_data_oe)
        else $error("output driven after reset");
    chk_write_quiet:
        assert property (wr_cmd && gap_r == 4'hf && !rd_data_oe |-> !rd_data_oe [*6])
        else $error("write drove the outputs");
    chk_burst_two:
        assert property ((rd_data_oe && rd_ready) [*2] |=> !rd_data_oe)
        else $error("burst longer than two words");
    chk_nop_idle:
        assert property (beat_phase && load_strobe_n && gap_r == 4'hf && !rd_data_oe
            |-> ##4 !rd_data_oe)
        else $error("no-operation started a read");
endmodule

// *** mem_ctrl_model.sv ***
// Memory controller model: beat marker, commands and write beats.
// Assumes the port samples every mclk rise, beat_phase marking the beat.
module mem_ctrl_model (
    // Clock
    input  wire logic  mclk,
    // Towards the port
    output logic       beat_phase,
    output logic       load_strobe_n,
    output logic       read_write_select,
    output logic [7:0] addr_in,
    output logic [35:0] wr_data,
    output logic [3:0] byte_lane_select_n
);
    // Idle levels at time zero
    initial begin
        beat_phase = 1'b0;
        load_strobe_n = 1'b1;
        read_write_select = 1'b1;
        addr_in = 8'h00;
        wr_data = 36'h0;
        byte_lane_select_n = 4'hf;
    end
    // single clock strap
    // Output timing follows mclk only; no separate output clock is driven
    // Beat marker alternates every cycle
    always @(posedge mclk) beat_phase <= ~beat_phase;
    task automatic cmd(input logic rd, input logic [7:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
        do @(posedge mclk); while (beat_phase !== 1'b0);
        load_strobe_n <= 1'b0;
        read_write_select <= rd;
        addr_in <= a;
        @(posedge mclk);
        load_strobe_n <= 1'b1;
        read_write_select <= 1'b1;
        addr_in <= ~a;
        if (!rd) begin
            @(posedge mclk);
            wr_data <= d0;
            byte_lane_select_n <= s0;
            @(posedge mclk);
            wr_data <= d1;
            byte_lane_select_n <= s1;
            @(posedge mclk);
            wr_data <= ~d1;
            byte_lane_select_n <= 4'hf;
        end
    endtask
endmodule

// *** ddr_sram_port_tb.sv ***
// Testbench for the burst SRAM port: writes, lane selects, reads, stalls.
// Assumes the controller model and checker are compiled first.
module ddr_sram_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        rd_ready = 1'b1;
    logic        beat_phase;
    logic        load_strobe_n;
    logic        read_write_select;
    logic [7:0]  addr_in;
    logic [35:0] wr_data;
    logic [3:0]  byte_lane_select_n;
    logic [35:0] rd_data;
    logic        rd_data_oe;
    int          bad_count = 0;
    int          check_count = 0;
    // Clock, 50 ns period
    always #25 mclk = ~mclk;
    // Controller model and port
    mem_ctrl_model i_mem_ctrl_model (.mclk, .beat_phase, .load_strobe_n,
        .read_write_select, .addr_in, .wr_data, .byte_lane_select_n);
    ddr_sram_port i_ddr_sram_port (.mclk, .clk_en(1'b1), .rst_b, .beat_phase,
        .load_strobe_n, .read_write_select, .addr_in, .wr_data,
        .byte_lane_select_n, .rd_data, .rd_data_oe, .rd_ready);
    // Compare and count
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One burst read, words on their fixed beats
    task automatic read_pair(input logic [7:0] a, input logic [35:0] e0, input logic [35:0] e1);
        i_mem_ctrl_model.cmd(1'b1, a, 36'h0, 36'h0, 4'hf, 4'hf);
        // First word is launched three edges after the command edge
        repeat (3) @(posedge mclk);
        #1 check("first oe", 36'h1, {35'h0, rd_data_oe});
        check("first word", e0, rd_data);
        @(posedge mclk);
        #1 check("second word", e1, rd_data);
        @(posedge mclk);
        #1 check("oe released", 36'h0, {35'h0, rd_data_oe});
    endtask
    // Quiet after reset and on idle beats
    task automatic t_idle();
        #1 check("oe after reset", 36'h0, {35'h0, rd_data_oe});
        repeat (12) @(posedge mclk);
        #1 check("oe idle", 36'h0, {35'h0, rd_data_oe});
    endtask
    // Full words, both burst orders
    task automatic t_words();
        i_mem_ctrl_model.cmd(1'b0, 8'h10, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        read_pair(8'h10, 36'h123456789, 36'hfedcba987);
        i_mem_ctrl_model.cmd(1'b0, 8'h31, 36'h0a5a5a5a5, 36'h05a5a5a5a, 4'h0, 4'h0);
        repeat (16) @(posedge mclk);
        read_pair(8'h30, 36'h05a5a5a5a, 36'h0a5a5a5a5);
        read_pair(8'h11, 36'hfedcba987, 36'h123456789);
    endtask
    // One lane on the first beat, none on the second
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            i_mem_ctrl_model.cmd(1'b0, 8'h40, 36'h0, 36'h0, 4'h0, 4'h0);
            i_mem_ctrl_model.cmd(1'b0, 8'h40, '1, '1, ~(4'h1 << i), 4'hf);
            read_pair(8'h40, 36'h1ff << (9 * i), 36'h0);
        end
    endtask
    // Stalled receiver: buffer full, extra read refused
    task automatic t_stall();
        @(posedge mclk);
        rd_ready <= 1'b0;
        i_mem_ctrl_model.cmd(1'b1, 8'h10, 36'h0, 36'h0, 4'hf, 4'hf);
        repeat (8) @(posedge mclk);
        i_mem_ctrl_model.cmd(1'b1, 8'h11, 36'h0, 36'h0, 4'hf, 4'hf);
        repeat (8) @(posedge mclk);
        #1 check("oe while stalled", 36'h0, {35'h0, rd_data_oe});
        @(posedge mclk);
        rd_ready <= 1'b1;
        @(posedge mclk);
        #1 check("held word", 36'h123456789, rd_data);
        @(posedge mclk);
        #1 check("next word", 36'hfedcba987, rd_data);
        @(posedge mclk);
        #1 check("no third word", 36'h0, {35'h0, rd_data_oe});
        repeat (8) @(posedge mclk);
        #1 check("refused read", 36'h0, {35'h0, rd_data_oe});
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(3000 * 50);
        bad_count++;
        close_out();
    end
    // Reset, then the scenarios
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_idle();
        t_words();
        t_lanes();
        t_stall();
        close_out();
    end
endmodule
bind ddr_sram_port ddr_sram_port_props #(.ADDR_W(ADDR_W), .LANES(LANES)) i_props (.mclk,
    .rst_b, .beat_phase, .load_strobe_n, .read_write_select, .rd_data, .rd_data_oe, .rd_ready);
